/* File: src/scs_pkg.sv */
/*
 * package for the clock-stop serial port: configuration, state and carriers.
 * assumes a single 125 mhz core clock and no register bus.
 */
package scs_pkg;

    // ------------------------------------------------------------
    // widths and field values
    // ------------------------------------------------------------
    localparam int DIV_W = 8;
    localparam int WORD_W = 8;
    localparam int BIT_W = 4;
    localparam logic [1:0] CLK_STOP_NO_DELAY = 2'h2;
    localparam logic [DIV_W-1:0] SLAVE_DIVIDER = 8'h01;
    localparam logic [DIV_W-1:0] DIV_ONE = 8'h01;
    localparam logic [BIT_W-1:0] BITS_LAST = 4'h7;
    // slave data-valid delay after enable falls, in core cycles
    localparam logic [2:0] SLAVE_DX_DELAY = 3'h4;

    // ------------------------------------------------------------
    // state machine and carriers
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE, ST_LEAD, ST_SHIFT, ST_TAIL, ST_HOLD
    } scs_state_type;

    typedef struct packed {
        logic master_mode;
        logic [1:0] clock_stop_select;
        logic tx_clock_polarity;
        logic rate_gen_source_select;
        logic [DIV_W-1:0] rate_gen_divider;
    } scs_cfg_type;

    typedef struct packed {
        logic serial_data_out;
        logic serial_data_oe;
        logic tx_bit_clock;
        logic tx_bit_clock_oe;
        logic tx_frame_sync;
        logic tx_frame_sync_oe;
    } scs_pins_type;

    typedef struct packed {
        scs_state_type state;
        logic [2:0] ext_sync;
        logic [1:0] bclk_sync;
        logic [1:0] fsx_sync;
        logic [1:0] fsr_sync;
        logic [1:0] din_sync;
        logic src_tick;
        logic [DIV_W-1:0] div_cnt;
        logic rg_clk;
        logic [DIV_W:0] phase_cnt;
        logic [BIT_W-1:0] bit_cnt;
        logic [WORD_W-1:0] tx_sh;
        logic [WORD_W-1:0] rx_sh;
        logic bclk_prev;
        logic en_prev;
        logic [2:0] dly;
        scs_pins_type pins;
        logic [WORD_W-1:0] rx_word;
        logic rx_valid;
        logic busy;
        logic tx_ready;
    } scs_state_all_type;

endpackage : scs_pkg

/* File: src/scs_port.sv */
/*
 * clock-stop serial port, mode "clock stop 10b, tx clock polarity 0",
 * acting as spi master or spi slave on 8-bit words.
 * assumes configuration is held stable while busy_out is high or changed
 * only between transfers; the pad logic resolves the three-signal pins.
 */
`timescale 1ns/1ns
// ------------------------------------------------------------
// Notes on behaviour
// ------------------------------------------------------------
// Notes on behaviour
// - rate input is two core cycles with source 1, external clock with 0
// - bit clock period is divider plus one rate-input periods, two when divider is zero
// - high phase divider/2+1 when even, (divider+1)/2 when odd or zero
// - low phase divider/2 when even, (divider+1)/2 when odd or zero
// - master drives tx frame sync inverted as active-low slave enable
// - slave inverts active-low enable on both frame-sync inputs
// - master drives tx clock and tx sync; rx clock and sync are inputs
// - slave mode forces source select 1 and divider 1
// - master lowers enable before rising clock edge starting the transfer
// - transmit data changes on rising bit clock edges
// - receive data sampled on falling bit clock edges
// - master asserts enable one low phase before first rising edge
// - master holds enable low one bit period after last falling edge
// - master releases data one low phase after last falling edge
// - slave releases data once enable returns high
// - slave drives first bit a few core cycles after enable falls
module scs_port import scs_pkg::*; (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // configuration
    input wire scs_cfg_type cfg_in,
    // transmit word handshake
    input wire logic [WORD_W-1:0] tx_word_in,
    input wire logic tx_start_in,
    // external pins, sampled through two flops
    input wire logic rate_gen_ext_clock_in,
    input wire logic tx_bit_clock_in,
    input wire logic tx_frame_sync_n_in,
    input wire logic rx_frame_sync_n_in,
    input wire logic serial_data_in,
    // pins driven
    output scs_pins_type pins_out,
    output logic rx_clock_dir_out,
    output logic rx_sync_dir_out,
    // status and received data
    output logic [WORD_W-1:0] rx_word_out,
    output logic rx_valid_out,
    output logic busy_out,
    output logic tx_ready_out
);

    scs_state_all_type s_q, s_d;

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic src_sel;
        logic [DIV_W-1:0] div;
        logic [DIV_W:0] hi_len;
        logic [DIV_W:0] lo_len;
        logic ext_rise;
        logic slv_en;
        logic bclk_now;
        logic rise;
        logic fall;
        logic active;
        s_d = s_q;
        s_d.rx_valid = 1'b0;
        // slave role pins the rate generator to a quarter of the core clock
        src_sel = cfg_in.master_mode ? cfg_in.rate_gen_source_select
                                     : 1'b1;
        div = cfg_in.master_mode ? cfg_in.rate_gen_divider
                                 : SLAVE_DIVIDER;
        active = (cfg_in.clock_stop_select == CLK_STOP_NO_DELAY) &&
                 !cfg_in.tx_clock_polarity;
        // input synchronisers
        s_d.ext_sync = {s_q.ext_sync[1:0], rate_gen_ext_clock_in};
        s_d.bclk_sync = {s_q.bclk_sync[0], tx_bit_clock_in};
        s_d.fsx_sync = {s_q.fsx_sync[0], tx_frame_sync_n_in};
        s_d.fsr_sync = {s_q.fsr_sync[0], rx_frame_sync_n_in};
        s_d.din_sync = {s_q.din_sync[0], serial_data_in};
        ext_rise = s_q.ext_sync[1] && !s_q.ext_sync[2];
        // rate input tick: every 2nd core cycle or per external rising edge
        s_d.src_tick = src_sel ? !s_q.src_tick : ext_rise;
        // phase lengths of the generated clock
        if (div[0] || div == '0) begin
            hi_len = ({1'b0, div} + 9'h001) >> 1;
            lo_len = ({1'b0, div} + 9'h001) >> 1;
        end else begin
            hi_len = ({1'b0, div} >> 1) + 9'h001;
            lo_len = {1'b0, div} >> 1;
        end
        // free-running rate generator output, period (1+div) ticks, 2 ticks when div is zero
        if (s_q.src_tick) begin
            if (s_q.phase_cnt == 9'h001 || s_q.phase_cnt == '0) begin
                s_d.rg_clk = !s_q.rg_clk;
                s_d.phase_cnt = s_q.rg_clk ? lo_len : hi_len;
            end else begin
                s_d.phase_cnt = s_q.phase_cnt - 9'h001;
            end
        end
        s_d.div_cnt = div;
        // slave enable inverted from either frame-sync input
        slv_en = !s_q.fsx_sync[1] || !s_q.fsr_sync[1];
        bclk_now = cfg_in.master_mode ? s_d.rg_clk : s_q.bclk_sync[1];
        rise = bclk_now && !s_q.bclk_prev;
        fall = !bclk_now && s_q.bclk_prev;
        s_d.bclk_prev = bclk_now;
        s_d.en_prev = slv_en;
        // master owns tx clock and tx sync; rx side are inputs
        s_d.pins.tx_bit_clock_oe = cfg_in.master_mode;
        s_d.pins.tx_frame_sync_oe = cfg_in.master_mode;
        // clock stops low between transfers
        s_d.pins.tx_bit_clock = cfg_in.master_mode &&
                                (s_q.state == ST_SHIFT) && s_d.rg_clk;
        // first rise leaves the lead state: show it on the pin at once
        if (rise && s_q.state == ST_LEAD && cfg_in.master_mode) begin
            s_d.pins.tx_bit_clock = 1'b1;
        end
        unique case (s_q.state)
            ST_IDLE: begin
                s_d.pins.tx_frame_sync = 1'b1;
                s_d.pins.serial_data_oe = 1'b0;
                s_d.busy = 1'b0;
                s_d.tx_ready = active;
                s_d.bit_cnt = '0;
                if (active && cfg_in.master_mode && tx_start_in &&
                    fall) begin
                    // enable low now: one low phase ahead of rise
                    s_d.tx_sh = tx_word_in;
                    s_d.pins.tx_frame_sync = 1'b0;
                    s_d.pins.serial_data_oe = 1'b1;
                    s_d.pins.serial_data_out = tx_word_in[WORD_W-1];
                    s_d.busy = 1'b1;
                    s_d.tx_ready = 1'b0;
                    s_d.state = ST_LEAD;
                end else if (active && !cfg_in.master_mode &&
                             slv_en && !s_q.en_prev) begin
                    s_d.tx_sh = tx_word_in;
                    s_d.dly = SLAVE_DX_DELAY;
                    s_d.busy = 1'b1;
                    s_d.tx_ready = 1'b0;
                    s_d.state = ST_LEAD;
                end
            end
            ST_LEAD: begin
                if (cfg_in.master_mode) begin
                    // transfer begins on the next rising edge
                    if (rise) begin
                        s_d.state = ST_SHIFT;
                    end
                end else if (s_q.dly == 3'h1) begin
                    s_d.pins.serial_data_oe = 1'b1;
                    s_d.pins.serial_data_out = s_q.tx_sh[WORD_W-1];
                    s_d.state = ST_SHIFT;
                end else begin
                    s_d.dly = s_q.dly - 3'h1;
                end
            end
            ST_SHIFT: begin
                // first rise keeps bit 7; later rises shift out
                if (rise && s_q.bit_cnt != '0) begin
                    s_d.pins.serial_data_out = s_q.tx_sh[WORD_W-1];
                end
                if (fall) begin
                    s_d.rx_sh = {s_q.rx_sh[WORD_W-2:0],
                                 s_q.din_sync[1]};
                    s_d.tx_sh = {s_q.tx_sh[WORD_W-2:0], 1'b0};
                    s_d.bit_cnt = s_q.bit_cnt + 4'h1;
                    if (s_q.bit_cnt == BITS_LAST) begin
                        s_d.rx_word = {s_q.rx_sh[WORD_W-2:0],
                                       s_q.din_sync[1]};
                        s_d.rx_valid = 1'b1;
                        s_d.state = ST_TAIL;
                    end
                end
                if (!cfg_in.master_mode && !slv_en) begin
                    s_d.pins.serial_data_oe = 1'b0;
                    s_d.state = ST_IDLE;
                end
            end
            ST_TAIL: begin
                if (cfg_in.master_mode) begin
                    // low phase after the last fall, then release data
                    if (rise) begin
                        s_d.pins.serial_data_oe = 1'b0;
                        s_d.state = ST_HOLD;
                    end
                end else if (!slv_en) begin
                    s_d.pins.serial_data_oe = 1'b0;
                    s_d.state = ST_IDLE;
                end
            end
            ST_HOLD: begin
                // enable stays low a full period past the last fall
                if (fall) begin
                    s_d.pins.tx_frame_sync = 1'b1;
                    s_d.state = ST_IDLE;
                end
            end
            default: begin
                s_d.state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
            s_q.state <= ST_IDLE;
            s_q.pins.tx_frame_sync <= 1'b1;
            // enable synchronisers start at the idle high level
            s_q.fsx_sync <= '1;
            s_q.fsr_sync <= '1;
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign pins_out = s_q.pins;
    assign rx_clock_dir_out = 1'b0;
    assign rx_sync_dir_out = 1'b0;
    assign rx_word_out = s_q.rx_word;
    assign rx_valid_out = s_q.rx_valid;
    assign busy_out = s_q.busy;
    assign tx_ready_out = s_q.tx_ready;

endmodule : scs_port

/* File: test/scs_port_monitor.sv */
/* checker for the clock-stop serial port, bound to every scs_port.
   assumes one core clock and the active-low asynchronous reset. */
`timescale 1ns/1ns
module scs_port_monitor import scs_pkg::*; (
    // watched ports
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire scs_cfg_type cfg_in,
    input wire logic tx_frame_sync_n_in,
    input wire logic rx_frame_sync_n_in,
    input wire scs_pins_type pins_out,
    input wire logic rx_clock_dir_out,
    input wire logic rx_sync_dir_out,
    input wire logic rx_valid_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic bc, fs, oe, so, m3, sl, en_hi;
    // short names; m3 is master with source 1 and divider 3
    assign bc = pins_out.tx_bit_clock;
    assign fs = pins_out.tx_frame_sync;
    assign oe = pins_out.serial_data_oe;
    assign so = pins_out.serial_data_out;
    assign sl = !cfg_in.master_mode;
    assign en_hi = tx_frame_sync_n_in && rx_frame_sync_n_in;
    assign m3 = !sl && cfg_in.rate_gen_source_select
        && cfg_in.rate_gen_divider == 8'h03;
    chk_rx_dirs_in: assert property (
        !rx_clock_dir_out && !rx_sync_dir_out) else $error("rx pins driven");
    chk_high_width: assert property (
        $rose(bc) && m3 |-> bc[*4] ##1 !bc) else $error("high phase width");
    chk_low_width: assert property (
        $fell(bc) && m3 |-> !bc[*4]) else $error("low phase short");
    chk_enable_lead: assert property (
        $fell(fs) && m3 |-> !bc[*4] ##1 bc) else $error("enable lead time");
    chk_data_on_rise: assert property (
        !sl && oe && $past(oe) && $changed(so) |-> bc)
        else $error("data changed off the rising edge");
    chk_enable_hold: assert property (
        !sl && $fell(oe) |-> !fs[*2] ##[1:8] fs) else $error("enable hold");
    chk_data_release: assert property (
        m3 && rx_valid_out |-> oe[*4] ##1 !oe)
        else $error("master data not released after one low phase");
    chk_rx_pulse: assert property (
        rx_valid_out |=> !rx_valid_out) else $error("valid longer than one");
    chk_slave_release: assert property (
        sl && en_hi[*6] |-> !oe) else $error("slave data not released");
    chk_slave_drive: assert property (
        sl && $past(sl, 2) && $fell(en_hi) |-> ##[3:9] oe)
        else $error("slave data not driven");
endmodule : scs_port_monitor
bind scs_port scs_port_monitor mon (.clk_in, .rst_n_in, .cfg_in,
    .tx_frame_sync_n_in, .rx_frame_sync_n_in, .pins_out,
    .rx_clock_dir_out, .rx_sync_dir_out, .rx_valid_out);

/* File: test/scs_peer.sv */
/* spi peer: a slave when the port leads, a master when lead_in is high.
   assumes go_in is pulsed only with lead_in high. */
`timescale 1ns/1ns
module scs_peer import scs_pkg::*; (
    // role, start and word
    input wire logic lead_in,
    input wire logic go_in,
    input wire logic [7:0] word_in,
    input wire scs_pins_type pins_in,
    // bus driven by the peer
    output logic bclk_out,
    output logic en_n_out,
    output logic sdo_out,
    output logic [7:0] got_out
);
    logic bc, be, first;
    logic [7:0] sh;
    assign bc = lead_in ? bclk_out : pins_in.tx_bit_clock;
    assign be = lead_in ? en_n_out : pins_in.tx_frame_sync;
    initial begin
        bclk_out = 0;
        en_n_out = 1;
        sdo_out = 0;
    end
    // led frame; the clock stands low outside it
    always @(posedge go_in) begin
        en_n_out = 0;
        // lead past the port's synchroniser and data delay
        #80;
        repeat (8) begin
            bclk_out = 1;
            #48;
            bclk_out = 0;
            #48;
        end
        en_n_out = 1;
    end
    // first bit with the enable, later bits on rising clock
    always @(negedge be) begin
        sh = word_in;
        sdo_out = sh[7];
        first = 1;
    end
    always @(posedge bc) if (!be) begin
        if (!first) begin
            sh = {sh[6:0], 1'b0};
            sdo_out = sh[7];
        end
        first = 0;
    end
    // take the port's data on the falling edge
    always @(negedge bc) if (!be) begin
        got_out = {got_out[6:0], pins_in.serial_data_out};
    end
    // a released line never keeps its last value
    always @(posedge be) sdo_out = ~sdo_out;
endmodule : scs_peer

/* File: test/scs_port_tb.sv */
/* self-checking bench for scs_port in master and slave roles.
   assumes scs_peer on the pins and the bound checker. */
`timescale 1ns/1ns
module scs_port_tb import scs_pkg::*;;
    logic clk_in, rst_n_in, tx_start_in, ext_clk, lead, go, sel_rx;
    logic rx_valid, busy, ready, bclk, en_n, sdo, bus_en, pb;
    logic [7:0] word, pword, rx_word, got;
    scs_cfg_type cfg;
    scs_pins_type pins;
    int mismatches, checks, cycles, hi, per, nb;
    int hq[$], pq[$];
    logic [7:0] rxq[$], txq[$];
    logic [31:0] lfsr = 32'h6720;
    assign bus_en = lead ? en_n : pins.tx_frame_sync;
    scs_port dut (.clk_in, .rst_n_in, .cfg_in(cfg), .tx_word_in(word),
        .tx_start_in, .rate_gen_ext_clock_in(ext_clk),
        .tx_bit_clock_in(bclk), .tx_frame_sync_n_in(sel_rx | en_n),
        .rx_frame_sync_n_in(!sel_rx | en_n), .serial_data_in(sdo),
        .pins_out(pins), .rx_clock_dir_out(), .rx_sync_dir_out(),
        .rx_word_out(rx_word), .rx_valid_out(rx_valid), .busy_out(busy),
        .tx_ready_out(ready));
    scs_peer peer (.lead_in(lead), .go_in(go), .word_in(pword),
        .pins_in(pins), .bclk_out(bclk), .en_n_out(en_n), .sdo_out(sdo),
        .got_out(got));
    // clocks: core 8 ns, external rate source 40 ns off the core edges
    initial begin
        clk_in = 0;
        forever #4 clk_in = ~clk_in;
    end
    initial begin
        ext_clk = 0;
        #3;
        forever #20 ext_clk = ~ext_clk;
    end
    // ----------------------------------------------------------------
    // compares, random words and closing
    // ----------------------------------------------------------------
    task automatic cmp_word(input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("[FAIL] %0t word exp %h got %h", $time, e, g);
        end
    endtask : cmp_word
    task automatic cmp_cyc(input int e, input int g);
        checks++;
        if (g != e) begin
            mismatches++;
            $display("[FAIL] %0t count exp %0d got %0d", $time, e, g);
        end
    endtask : cmp_cyc
    function automatic logic [7:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr[7:0];
    endfunction : rnd
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test
    always @(posedge clk_in) if (++cycles > 5000) begin
        mismatches++;
        finish_test();
    end
    // watchers: words at the port and the peer, bit clock widths
    // outputs read on the falling core edge, clear of the launch edge
    always @(negedge clk_in) if (rx_valid === 1'b1) begin
        if (rxq.size() == 0) cmp_cyc(1, 0);
        else cmp_word(rxq.pop_front(), rx_word);
    end
    always @(posedge bus_en) if (txq.size()) begin
        cmp_word(txq.pop_front(), got);
    end
    always @(negedge clk_in) begin
        if (bus_en) per = -99;
        if (pins.tx_bit_clock && !pb && !lead) begin
            if (per > 0) cmp_cyc(pq.pop_front(), per);
            per = 0;
        end
        if (!pins.tx_bit_clock && pb && !lead) begin
            cmp_cyc(hq.pop_front(), hi);
            hi = 0;
        end
        hi = pins.tx_bit_clock ? hi + 1 : 0;
        per++;
        pb = pins.tx_bit_clock;
    end
    // master transfer: hold the request until busy answers
    task automatic mx(input logic [7:0] w, input int h, input int p);
        int n;
        pword = rnd();
        word = w;
        tx_start_in = 1;
        rxq.push_back(pword);
        txq.push_back(w);
        repeat (8) hq.push_back(h);
        repeat (7) pq.push_back(p);
        for (n = 0; n < 100 && busy !== 1'b1; n++) begin
            @(posedge clk_in);
            #1;
        end
        tx_start_in = 0;
        for (n = 0; n < 300 && busy !== 1'b0; n++) begin
            @(posedge clk_in);
            #1;
        end
        repeat (16) @(posedge clk_in);
        #1 cmp_cyc(0, hq.size() + pq.size() + txq.size() + rxq.size());
    endtask : mx
    int srcs[3] = '{1, 1, 0};
    int divs[3] = '{3, 2, 1};
    int his[3] = '{4, 4, 5};
    int pers[3] = '{8, 6, 10};
    initial begin
        {tx_start_in, go, lead, sel_rx, word, pword, pb} = '0;
        cfg = '{1'b1, CLK_STOP_NO_DELAY, 1'b0, 1'b1, 8'h03};
        rst_n_in = 0;
        repeat (8) @(posedge clk_in);
        #1 rst_n_in = 1;
        repeat (3) @(posedge clk_in);
        #1 cmp_word(8'h01, ready);
        // master role over the rate settings, back to back
        for (int i = 0; i < 3; i++) begin
            cfg.rate_gen_source_select = srcs[i][0];
            cfg.rate_gen_divider = divs[i][7:0];
            repeat (2) mx(rnd(), his[i], pers[i]);
        end
        // slave role on each enable input, settings left wrong
        {lead, cfg.master_mode, cfg.rate_gen_divider} = 10'h200;
        for (int r = 0; r < 2; r++) begin
            sel_rx = r[0];
            pword = rnd();
            word = rnd();
            rxq.push_back(pword);
            txq.push_back(word);
            go = 1;
            @(posedge clk_in);
            #1 go = 0;
            repeat (112) @(posedge clk_in);
            #1 cmp_cyc(0, txq.size() + rxq.size());
        end
        // refused modes: no transfer starts
        {lead, sel_rx, cfg.master_mode, tx_start_in} = 4'h3;
        for (int k = 0; k < 2; k++) begin
            cfg.clock_stop_select = k ? 2'h2 : 2'h1;
            cfg.tx_clock_polarity = k[0];
            nb = 0;
            repeat (60) @(negedge clk_in) nb += (busy !== 1'b0);
            @(posedge clk_in);
            #1 cmp_cyc(0, nb + (ready !== 1'b0));
        end
        finish_test();
    end
endmodule : scs_port_tb
